// >>> ncb_host.sv
// Host side of an asynchronous 8-bit multiplexed NAND flash bus.
// Assumes one 100 MHz clock, pins treated as synchronous to it, and an
// external pull-up on the ready/busy line.
`timescale 1ns/1ps
module ncb_host (
   input  wire logic                     clk_i,
   input  wire logic                     reset_n_i,
   // User request port.
   input  wire logic                     req_valid_i,
   output logic                          req_ready_o,
   input  wire ncb_pkg::ncb_kind_t       req_kind_i,
   input  wire logic [7:0]               req_byte_i,
   input  wire logic [ncb_pkg::COL_W-1:0] req_col_i,
   input  wire logic [ncb_pkg::ROW_W-1:0] req_row_i,
   input  wire logic [2:0]               req_addr_cycles_i,
   output logic                          done_o,
   output logic                          err_o,
   // Read data stream.
   output logic [7:0]                    rd_data_o,
   output logic                          rd_valid_o,
   input  wire logic                     rd_ready_i,
   // Levels for the select and write protect pins.
   input  wire logic                     select_i,
   input  wire logic                     write_enable_i,
   // Flash pins.
   output logic                          ce_n_o,
   output logic                          cle_o,
   output logic                          ale_o,
   output logic                          we_n_o,
   output logic                          read_strobe_n_o,
   output logic                          wp_n_o,
   output logic [7:0]                    io_o,
   output logic                          io_oe_o,
   input  wire logic [7:0]               io_i,
   input  wire logic                     ready_busy_n_i
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_WR_LO, ST_WR_HI, ST_RD_LO, ST_RD_HI, ST_WB, ST_RB
   } ncb_state_t;

   ncb_state_t                     state_reg,  state_next;
   ncb_pkg::ncb_kind_t             kind_reg,   kind_next;
   logic [3:0]                     cnt_reg,    cnt_next;
   logic [2:0]                     idx_reg,    idx_next;
   logic [2:0]                     ncyc_reg,   ncyc_next;
   logic [ncb_pkg::COL_W-1:0]      col_reg,    col_next;
   logic [ncb_pkg::ROW_W-1:0]      row_reg,    row_next;
   logic                           cle_reg,    cle_next;
   logic                           ale_reg,    ale_next;
   logic                           we_n_reg,   we_n_next;
   logic                           rs_n_reg,   rs_n_next;
   logic [7:0]                     io_reg,     io_next;
   logic                           io_oe_reg,  io_oe_next;
   logic                           rdy_reg,    rdy_next;
   logic                           done_reg,   done_next;
   logic                           err_reg,    err_next;
   logic                           push_v_reg, push_v_next;
   logic [7:0]                     push_d_reg, push_d_next;
   logic                           ce_n_reg;
   logic                           wp_n_reg;

   ncb_strm_if push_if ();
   ncb_strm_if pop_if ();

   // ----------------------------------------------------------------
   // Request decode.
   // ----------------------------------------------------------------
   wire accept      = rdy_reg && req_valid_i;
   wire is_cmd      = (req_kind_i == ncb_pkg::NCB_K_CMD);
   wire is_addr     = (req_kind_i == ncb_pkg::NCB_K_ADDR);
   wire cmd_undef   = is_cmd && !ncb_pkg::ncb_cmd_defined(req_byte_i);
   wire cmd_in_busy = (req_byte_i == ncb_pkg::CMD_RESET) ||
                      (req_byte_i == ncb_pkg::CMD_STATUS) ||
                      (req_byte_i == ncb_pkg::CMD_STATUS_ENH);
   wire cmd_busy_bad = is_cmd && !ready_busy_n_i && !cmd_in_busy;
   // Column beyond main plus spare, or a cycle count the device lacks.
   wire addr_bad    = is_addr && ((req_col_i >= ncb_pkg::PAGE_BYTES) ||
                      (req_addr_cycles_i == 3'h0) ||
                      (req_addr_cycles_i > ncb_pkg::MAX_ADDR_CYC));
   wire req_bad     = cmd_undef || cmd_busy_bad || addr_bad;
   wire cnt_end     = (cnt_reg == 4'h0);
   wire more_addr   = (kind_reg == ncb_pkg::NCB_K_ADDR) && ((idx_reg + 3'h1) < ncyc_reg);
   wire [7:0] first_addr = ncb_pkg::ncb_addr_byte(req_col_i, req_row_i, 3'h0);
   wire [7:0] next_addr  = ncb_pkg::ncb_addr_byte(col_reg, row_reg, idx_reg + 3'h1);

   // ----------------------------------------------------------------
   // Bus sequencer. Every pin level is registered, so pins never glitch.
   // ----------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      kind_next   = kind_reg;
      cnt_next    = cnt_reg;
      idx_next    = idx_reg;
      ncyc_next   = ncyc_reg;
      col_next    = col_reg;
      row_next    = row_reg;
      cle_next    = cle_reg;
      ale_next    = ale_reg;
      we_n_next   = we_n_reg;
      rs_n_next   = rs_n_reg;
      io_next     = io_reg;
      io_oe_next  = io_oe_reg;
      done_next   = 1'h0;
      err_next    = 1'h0;
      push_v_next = 1'h0;
      push_d_next = push_d_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (accept && req_bad) begin
               err_next = 1'h1;
            end else if (accept) begin
               kind_next = req_kind_i;
               col_next  = req_col_i;
               row_next  = req_row_i;
               ncyc_next = req_addr_cycles_i;
               idx_next  = 3'h0;
               unique case (req_kind_i)
                  ncb_pkg::NCB_K_RDATA: begin
                     rs_n_next  = 1'h0;
                     io_oe_next = 1'h0;
                     cnt_next   = ncb_pkg::RD_ACC_CYC - 4'h1;
                     state_next = ST_RD_LO;
                  end
                  ncb_pkg::NCB_K_WAIT: begin
                     cnt_next   = ncb_pkg::BUSY_ONSET_CYC - 4'h1;
                     state_next = ST_WB;
                  end
                  default: begin
                     // Qualifiers pick the byte's meaning; both low means data.
                     cle_next   = is_cmd;
                     ale_next   = is_addr;
                     io_next    = is_addr ? first_addr : req_byte_i;
                     io_oe_next = 1'h1;
                     we_n_next  = 1'h0;
                     cnt_next   = ncb_pkg::WR_LOW_CYC - 4'h1;
                     state_next = ST_WR_LO;
                  end
               endcase
            end
         end
         ST_WR_LO: begin
            if (cnt_end) begin
               we_n_next  = 1'h1;
               cnt_next   = ncb_pkg::WR_HIGH_CYC - 4'h1;
               state_next = ST_WR_HI;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_WR_HI: begin
            // Byte and qualifiers are held through the high time after the edge.
            if (cnt_end && more_addr) begin
               idx_next   = idx_reg + 3'h1;
               io_next    = next_addr;
               we_n_next  = 1'h0;
               cnt_next   = ncb_pkg::WR_LOW_CYC - 4'h1;
               state_next = ST_WR_LO;
            end else if (cnt_end) begin
               cle_next   = 1'h0;
               ale_next   = 1'h0;
               io_oe_next = 1'h0;
               done_next  = 1'h1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_RD_LO: begin
            // Sampling waits out the access delay from the falling edge.
            if (cnt_end) begin
               push_v_next = 1'h1;
               push_d_next = io_i;
               rs_n_next   = 1'h1;
               cnt_next    = ncb_pkg::RD_HIGH_CYC - 4'h1;
               state_next  = ST_RD_HI;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_RD_HI: begin
            if (cnt_end) begin
               done_next  = 1'h1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_WB: begin
            // The busy line may take a while to fall after the command.
            if (cnt_end) begin
               state_next = ST_RB;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_RB: begin
            if (ready_busy_n_i) begin
               done_next  = 1'h1;
               state_next = ST_IDLE;
            end
         end
      endcase
      // Requests stop while a read byte could find no room.
      rdy_next = (state_next == ST_IDLE) && push_if.ready && !push_v_next;
   end

   // Sequencer state.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         kind_reg  <= ncb_pkg::NCB_K_CMD;
         cnt_reg   <= 4'h0;
         idx_reg   <= 3'h0;
         ncyc_reg  <= 3'h0;
         col_reg   <= '0;
         row_reg   <= '0;
      end else begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         cnt_reg   <= cnt_next;
         idx_reg   <= idx_next;
         ncyc_reg  <= ncyc_next;
         col_reg   <= col_next;
         row_reg   <= row_next;
      end
   end

   // Pin and handshake flops.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cle_reg    <= 1'h0;
         ale_reg    <= 1'h0;
         we_n_reg   <= 1'h1;
         rs_n_reg   <= 1'h1;
         io_reg     <= 8'h00;
         io_oe_reg  <= 1'h0;
         rdy_reg    <= 1'h0;
         done_reg   <= 1'h0;
         err_reg    <= 1'h0;
         push_v_reg <= 1'h0;
         push_d_reg <= 8'h00;
      end else begin
         cle_reg    <= cle_next;
         ale_reg    <= ale_next;
         we_n_reg   <= we_n_next;
         rs_n_reg   <= rs_n_next;
         io_reg     <= io_next;
         io_oe_reg  <= io_oe_next;
         rdy_reg    <= rdy_next;
         done_reg   <= done_next;
         err_reg    <= err_next;
         push_v_reg <= push_v_next;
         push_d_reg <= push_d_next;
      end
   end

   // Select and protect levels; reset deselects and protects the array.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ce_n_reg <= 1'h1;
         wp_n_reg <= 1'h0;
      end else begin
         ce_n_reg <= !select_i;
         wp_n_reg <= write_enable_i;
      end
   end

   // ----------------------------------------------------------------
   // Read byte buffer and outputs.
   // ----------------------------------------------------------------
   assign push_if.valid = push_v_reg;
   assign push_if.data  = push_d_reg;
   assign pop_if.ready  = rd_ready_i;

   ncb_buf2 u_buf (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .in_if     (push_if.snk),
      .out_if    (pop_if.src)
   );

   assign rd_data_o       = pop_if.data;
   assign rd_valid_o      = pop_if.valid;
   assign req_ready_o     = rdy_reg;
   assign done_o          = done_reg;
   assign err_o           = err_reg;
   assign ce_n_o          = ce_n_reg;
   assign cle_o           = cle_reg;
   assign ale_o           = ale_reg;
   assign we_n_o          = we_n_reg;
   assign read_strobe_n_o = rs_n_reg;
   assign wp_n_o          = wp_n_reg;
   assign io_o            = io_reg;
   assign io_oe_o         = io_oe_reg;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_we_low;
      (!we_n_o && io_oe_o) [*2];
   endsequence
   sequence s_rd_wait;
      (!read_strobe_n_o && !push_v_reg) [*3];
   endsequence

   we_low_time_a: assert property ($fell(we_n_o) |-> s_we_low ##1 we_n_o)
      else $error("Write strobe low time wrong.");
   we_edge_hold_a: assert property ($rose(we_n_o) |-> io_oe_o && $stable(io_o)
                                    && $stable(cle_o) && $stable(ale_o))
      else $error("Byte or qualifier moved at the write strobe edge.");
   qual_excl_a: assert property (!(cle_o && ale_o))
      else $error("Both capture qualifiers high.");
   read_sample_a: assert property ($fell(read_strobe_n_o) |-> s_rd_wait
                                   ##1 (push_v_reg && read_strobe_n_o))
      else $error("Read byte not taken after the access delay.");
   read_float_a: assert property (!read_strobe_n_o |-> !io_oe_o && we_n_o)
      else $error("Host drives the bus during a read strobe.");
   addr_high_zero_a: assert property (ale_o && !we_n_o && idx_reg == 3'h1
                                      |-> io_o[7:4] == 4'h0)
      else $error("Second address cycle upper bits not low.");
   addr_row_top_a: assert property (ale_o && !we_n_o && idx_reg == 3'h4
                                    |-> io_o == {5'h00, row_reg[18:16]})
      else $error("Fifth address cycle carries wrong bits.");
   bad_cmd_refuse_a: assert property (accept && cmd_undef
                                      |=> err_o && we_n_o && !cle_o)
      else $error("Undefined command reached the bus.");
   busy_cmd_refuse_a: assert property (accept && cmd_busy_bad
                                       |=> err_o && state_reg == ST_IDLE)
      else $error("Command sent while the device is busy.");
   select_follow_a: assert property ($past(reset_n_i) |-> ce_n_o == !$past(select_i))
      else $error("Chip select does not follow the select input.");
   wait_ready_a: assert property (state_reg == ST_RB && !ready_busy_n_i
                                  |=> !done_o)
      else $error("Wait finished while the device is busy.");

endmodule : ncb_host

// >>> ncb_pkg.sv
// Constants, types and helpers for the NAND bus host controller.
// Assumes one 100 MHz clock and a single flash die behind the pins.
//
// Operation
// - Bytes are taken at write strobe rise.
// - Address qualifier high loads the address register.
// - Command qualifier high loads the command register.
// - One shared eight-bit bus for everything.
// - Cycles one and two carry column bits.
// - Cycles three to five carry row bits.
// - Unused upper bits of cycles two, five low.
// - While busy, only reset or status commands.
// - Never send an undefined command code.
package ncb_pkg;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_MHZ              = 100;
   localparam int WR_LOW_NS            = 20;
   localparam int WR_HIGH_NS           = 20;
   localparam int READ_ACCESS_DELAY_NS = 25;
   localparam int RD_HIGH_NS           = 20;
   localparam int BUSY_ONSET_NS        = 100;
   // Least times round up to whole cycles.
   localparam logic [3:0] WR_LOW_CYC  = 4'((WR_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WR_HIGH_CYC = 4'((WR_HIGH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RD_ACC_CYC  = 4'((READ_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RD_HIGH_CYC = 4'((RD_HIGH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] BUSY_ONSET_CYC = 4'((BUSY_ONSET_NS * CLK_MHZ + 999) / 1000);

   // ----------------------------------------------------------------
   // Array geometry and address layout.
   // ----------------------------------------------------------------
   localparam int          MAIN_BYTES   = 2048;
   localparam int          SPARE_BYTES  = 64;
   localparam logic [11:0] PAGE_BYTES   = 12'(MAIN_BYTES + SPARE_BYTES);
   localparam int          PAGES_PER_BLK = 64;
   localparam int          BLOCKS       = 8192;
   localparam int          COL_W        = 12;
   localparam int          ROW_W        = 19;
   localparam int          PLANE_ROW_BIT = 6;     // Row bit 6 is address bit 18.
   localparam logic [2:0]  MAX_ADDR_CYC = 3'h5;
   localparam logic [3:0]  HI_NIB_ZERO  = 4'h0;
   localparam logic [4:0]  HI_5_ZERO    = 5'h00;

   // ----------------------------------------------------------------
   // Command codes with special treatment while busy.
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_RESET       = 8'hFF;
   localparam logic [7:0] CMD_STATUS      = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;

   typedef enum logic [2:0] {
      NCB_K_CMD,
      NCB_K_ADDR,
      NCB_K_WDATA,
      NCB_K_RDATA,
      NCB_K_WAIT
   } ncb_kind_t;

   // True for every code that the device defines.
   function automatic logic ncb_cmd_defined(input logic [7:0] c);
      unique case (c)
         8'h00, 8'h05, 8'h06, 8'h10, 8'h11, 8'h15, 8'h30, 8'h31, 8'h35,
         8'h3F, 8'h60, 8'h70, 8'h78, 8'h80, 8'h81, 8'h85, 8'h90, 8'hD0,
         8'hD1, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hFF: return 1'h1;
         default: return 1'h0;
      endcase
   endfunction : ncb_cmd_defined

   // Byte sent in address cycle idx (0 based) for a column and row.
   function automatic logic [7:0] ncb_addr_byte(input logic [COL_W-1:0] col,
                                                input logic [ROW_W-1:0] row,
                                                input logic [2:0]       idx);
      unique case (idx)
         3'h0:    return col[7:0];
         3'h1:    return {HI_NIB_ZERO, col[11:8]};
         3'h2:    return row[7:0];
         3'h3:    return row[15:8];
         3'h4:    return {HI_5_ZERO, row[18:16]};
         default: return 8'h00;
      endcase
   endfunction : ncb_addr_byte

endpackage : ncb_pkg

// >>> ncb_strm_if.sv
// Valid/ready byte stream between the controller's own modules.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface ncb_strm_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ncb_strm_if

// >>> ncb_buf2.sv
// Two-entry buffer for bytes read from the flash.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ncb_buf2 (
   input  wire logic   clk_i,
   input  wire logic   reset_n_i,
   ncb_strm_if.snk     in_if,
   ncb_strm_if.src     out_if
);
   logic [7:0] mem_reg [0:1];   // Entry 0 is the head and drives the output.
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic       valid_reg;
   logic       full_reg;
   wire        push      = in_if.valid && !full_reg;
   wire        pop       = out_if.ready && valid_reg;
   wire        load_head = push && ((count_reg == 2'h0) || pop);
   wire        load_tail = push && (count_reg == 2'h1) && !pop;
   wire        move_up   = pop && (count_reg == 2'h2);

   // ----------------------------------------------------------------
   // Occupancy; full and empty are flops so the ports stay glitch free.
   // ----------------------------------------------------------------
   assign count_next   = count_reg + {1'h0, push} - {1'h0, pop};
   assign in_if.ready  = !full_reg;
   assign out_if.valid = valid_reg;
   assign out_if.data  = mem_reg[0];   // Straight from a flop, no read mux.

   // Occupancy count and flags.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg  <= 2'h0;
         valid_reg  <= 1'h0;
         full_reg   <= 1'h0;
      end else begin
         count_reg  <= count_next;
         valid_reg  <= (count_next != 2'h0);
         full_reg   <= (count_next == 2'h2);
      end
   end

   // Storage needs no reset; valid guards it. A full buffer takes no push,
   // so moving the tail up never meets a load of the head.
   always_ff @(posedge clk_i) begin
      if (move_up) begin
         mem_reg[0] <= mem_reg[1];
      end else if (load_head) begin
         mem_reg[0] <= in_if.data;
      end
      if (load_tail) begin
         mem_reg[1] <= in_if.data;
      end
   end

   // A push is never offered into a full buffer.
   no_overflow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      in_if.valid |-> !full_reg)
      else $error("Read byte pushed into a full buffer.");

   // A held word stays put while the receiver stalls.
   stall_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      out_if.valid && !out_if.ready |=> out_if.valid && $stable(out_if.data))
      else $error("Stalled read byte changed or vanished.");

endmodule : ncb_buf2

// >>> ncb_flash_model.sv
// Behavioural flash device standing on the far side of the host pins.
// Assumes the bench resolves the shared data bus and the ready pull-up.
`timescale 1ns/1ps
module ncb_flash_model #(
   parameter int ACC_NS  = ncb_pkg::READ_ACCESS_DELAY_NS,
   parameter int BUSY_NS = 400
) (
   input  wire logic       ce_n_i,
   input  wire logic       cle_i,
   input  wire logic       ale_i,
   input  wire logic       we_n_i,
   input  wire logic       re_n_i,
   input  wire logic       wp_n_i,
   input  wire logic [7:0] io_i,
   output logic [7:0]      io_o,
   output logic            io_oe_o,
   output logic            busy_o
);
   logic [7:0]  cmd_reg;
   logic [7:0]  addr_reg [0:4];
   logic [2:0]  n_addr = 3'h0;
   logic [11:0] col = 12'h000;
   logic [7:0]  wdata_reg = 8'h00;
   int          n_prog = 0;
   initial begin
      io_o = 8'h00;
      io_oe_o = 1'b0;
      busy_o = 1'b0;
   end
   // Bytes land at the write strobe rise, sorted by the two qualifiers.
   always @(posedge we_n_i) if (!ce_n_i) begin
      if (cle_i) begin
         cmd_reg = io_i;
         n_addr = 3'h0;
         if ((io_i == 8'h10 || io_i == 8'hD0) && wp_n_i) begin
            n_prog++;
            busy_o = 1'b1;
            busy_o <= #(BUSY_NS) 1'b0;
         end
      end else if (ale_i) begin
         if (n_addr < 3'h5) begin
            addr_reg[n_addr] = io_i;
            n_addr++;
            col = {addr_reg[1][3:0], addr_reg[0]};
         end
      end else begin
         wdata_reg = io_i;
         col++;
      end
   end
   // Junk shows until the access delay ends, so an early sample fails.
   always @(negedge re_n_i) if (!ce_n_i) begin
      io_oe_o = 1'b1;
      io_o = ~io_o;
      io_o <= #(ACC_NS) col[7:0] ^ 8'hA5;
      col++;
   end
   // A released bus shows the inverse of the last byte, never a held value.
   always @(posedge re_n_i or posedge ce_n_i) begin
      io_o <= #5 ~io_o;
      io_oe_o <= #5 1'b0;
   end
endmodule : ncb_flash_model

// >>> tb_top.sv
// Self-checking bench for the NAND bus host controller.
// Assumes the package, the stream interface and the flash model compile first.
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0, reset_n_i = 1'b0, req_valid_i = 1'b0, rd_ready_i = 1'b0;
   logic select_i = 1'b1, write_enable_i = 1'b1;
   ncb_pkg::ncb_kind_t req_kind_i = ncb_pkg::NCB_K_CMD;
   logic [7:0]  req_byte_i = 8'h00;
   logic [11:0] req_col_i = 12'h83A;
   logic [18:0] req_row_i = 19'h54321;
   logic [2:0]  req_addr_cycles_i = 3'h5;
   logic req_ready_o, done_o, err_o, rd_valid_o, ce_n_o, cle_o, ale_o, we_n_o, rs_n, wp_n_o;
   logic io_oe_o, m_oe, busy;
   logic [7:0] rd_data_o, io_o, m_io, io_i;
   int mismatches = 0, n_compared = 0, cyc = 0;
   assign io_i = io_oe_o ? io_o : m_io;
   ncb_host i_ncb_host (.clk_i, .reset_n_i, .req_valid_i, .req_ready_o, .req_kind_i,
      .req_byte_i, .req_col_i, .req_row_i, .req_addr_cycles_i, .done_o, .err_o,
      .rd_data_o, .rd_valid_o, .rd_ready_i, .select_i, .write_enable_i, .ce_n_o, .cle_o,
      .ale_o, .we_n_o, .read_strobe_n_o(rs_n), .wp_n_o, .io_o, .io_oe_o, .io_i,
      .ready_busy_n_i(~busy));
   ncb_flash_model i_ncb_flash_model (.ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o),
      .we_n_i(we_n_o), .re_n_i(rs_n), .wp_n_i(wp_n_o), .io_i(io_o), .io_o(m_io),
      .io_oe_o(m_oe), .busy_o(busy));
   initial forever #5 clk_i = ~clk_i;
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Offers one request, waits for its answer and checks the refusal flag.
   task automatic req(input ncb_pkg::ncb_kind_t k, input logic [7:0] b, input logic e);
      int i;
      req_kind_i = k;
      req_byte_i = b;
      req_valid_i = 1'b1;
      @(negedge clk_i);
      while (req_ready_o !== 1'b1) @(negedge clk_i);
      @(posedge clk_i) #1 req_valid_i = 1'b0;
      for (i = 0; i < 2000 && !(done_o === 1'b1 || err_o === 1'b1); i++) @(posedge clk_i) #1;
      chk({done_o, err_o}, {~e, e});
   endtask : req
   task automatic t_sel();
      select_i = 1'b0;
      repeat (2) @(posedge clk_i) #1;
      chk(ce_n_o, 1'b1);
      select_i = 1'b1;
      repeat (2) @(posedge clk_i) #1;
      chk(ce_n_o, 1'b0);
   endtask : t_sel
   task automatic t_cmd_addr();
      req(ncb_pkg::NCB_K_CMD, 8'h70, 1'b0);
      chk(i_ncb_flash_model.cmd_reg, 8'h70);
      req(ncb_pkg::NCB_K_ADDR, 8'h00, 1'b0);
      chk({i_ncb_flash_model.addr_reg[0], i_ncb_flash_model.addr_reg[1],
         i_ncb_flash_model.addr_reg[2], i_ncb_flash_model.addr_reg[3],
         i_ncb_flash_model.addr_reg[4]}, 40'h3A08214305);
      req_addr_cycles_i = 3'h6;
      req(ncb_pkg::NCB_K_ADDR, 8'h00, 1'b1);
      req_addr_cycles_i = 3'h5;
      req_col_i = 12'h840;
      req(ncb_pkg::NCB_K_ADDR, 8'h00, 1'b1);
      req(ncb_pkg::NCB_K_CMD, 8'h01, 1'b1);
   endtask : t_cmd_addr
   // Two reads queue while the receiver stalls, then drain in order.
   task automatic t_read();
      int i;
      req(ncb_pkg::NCB_K_RDATA, 8'h00, 1'b0);
      req(ncb_pkg::NCB_K_RDATA, 8'h00, 1'b0);
      for (i = 0; i < 2; i++) begin
         chk(rd_valid_o, 1'b1);
         chk(rd_data_o, 8'h9F ^ 8'(i));
         rd_ready_i = 1'b1;
         @(posedge clk_i) #1 rd_ready_i = 1'b0;
      end
      chk(rd_valid_o, 1'b0);
      chk(m_oe, 1'b0);
   endtask : t_read
   task automatic t_prog();
      req(ncb_pkg::NCB_K_WDATA, 8'h5A, 1'b0);
      chk(i_ncb_flash_model.wdata_reg, 8'h5A);
      write_enable_i = 1'b0;
      repeat (2) @(posedge clk_i) #1;
      req(ncb_pkg::NCB_K_CMD, 8'h10, 1'b0);
      chk(i_ncb_flash_model.n_prog, 1'b0);
      write_enable_i = 1'b1;
      repeat (2) @(posedge clk_i) #1;
      req(ncb_pkg::NCB_K_CMD, 8'h10, 1'b0);
      req(ncb_pkg::NCB_K_CMD, 8'h00, 1'b1);
      req(ncb_pkg::NCB_K_CMD, 8'h70, 1'b0);
      chk(busy, 1'b1);
      req(ncb_pkg::NCB_K_WAIT, 8'h00, 1'b0);
      chk({busy, 8'(i_ncb_flash_model.n_prog)}, 9'h001);
   endtask : t_prog
   task automatic report_and_stop();
      $display("compared=%0d mismatches=%0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      repeat (2) @(posedge clk_i) #1;
      t_sel();
      t_cmd_addr();
      t_read();
      t_prog();
      report_and_stop();
   end
endmodule : tb_top
